// *** hw/video_decoder_event_interrupts.sv ***
// event interrupt controller of the video decoder with a wishbone slave
// ---------------------------------------------------------------
// Summary of operation
// ---------------------------------------------------------------
// Summary of operation
// R1: one interrupt output toward the host, shared by all sources.
// R2: eleven sources, each enabled or disabled independently at any time.
// R3: readable status register records which events occurred.
// R4: decoding is unaffected by the enables and by the interrupt line.
// R5: raise events on bitstream buffer underflow and on data error.
// R6: raise events on picture decoded, sequence header, sequence end, scan done.
// R7: at vsync, raise event on last picture shown before sequence end.
// R8: at vsync, raise events on first intra picture after group and sequence start.
// R9: at vsync, raise picture-shown event; raise ready-for-data event.
// R10: host selects enabled sources through the enable-setting command.
// R11: line high while any enabled status bit set; host clears by writing ones.
`timescale 1ns/1ns
module video_decoder_event_interrupts
    import vd_irq_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output      logic [31:0] wb_dat_o,
    output      logic        wb_ack_o,
    // decode-time event pulses from the decoder core
    input  wire logic        seq_end_found_evt,
    input  wire logic        data_error_evt,
    input  wire logic        picture_decoded_evt,
    input  wire logic        seq_header_decoded_evt,
    input  wire logic        scan_decode_done_evt,
    input  wire logic        buffer_underflow_evt,
    // display-time event pulses from the video output unit
    input  wire logic        last_pic_shown_raw,
    input  wire logic        group_start_shown_raw,
    input  wire logic        picture_shown_raw,
    input  wire logic        seq_start_shown_raw,
    input  wire logic        ready_for_data_evt,
    // vertical sync pin
    input  wire logic        vsync_pin,
    // interrupt to host
    output      logic        irq
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [NUM_SRC-1:0] status;
    logic [NUM_SRC-1:0] enable;
    logic [NUM_SRC-1:0] evt;
    logic [NUM_SRC-1:0] clr;
    logic [3:0]         vtimed;
    logic               vsync_s1;
    logic               vsync_s2;
    logic               wb_req;
    logic               wr_fire;

    function automatic logic [31:0] pad(input logic [NUM_SRC-1:0] v);
        pad = {21'h000000, v};
    endfunction

    // ---------------------------------------------------------------
    // vsync synchroniser and display-time alignment
    // ---------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            vsync_s1 <= 1'b0;
            vsync_s2 <= 1'b0;
        end
        else
        begin
            vsync_s1 <= vsync_pin;
            vsync_s2 <= vsync_s1;
        end
    end

    vsync_event_align #(
        .WIDTH (4)
    ) u_align (
        .clock     (clock),
        .resetn    (resetn),
        .vsync     (vsync_s2),
        .raw_evt   ({seq_start_shown_raw, picture_shown_raw,
                     group_start_shown_raw, last_pic_shown_raw}),
        .timed_evt (vtimed)
    );

    // ---------------------------------------------------------------
    // event collection
    // ---------------------------------------------------------------
    always_comb
    begin
        evt                 = '0;
        evt[BIT_SEQ_END_D]  = seq_end_found_evt;      // R6
        evt[BIT_DATA_ERR]   = data_error_evt;         // R5
        evt[BIT_PIC_DEC]    = picture_decoded_evt;    // R6
        evt[BIT_SEQ_HDR]    = seq_header_decoded_evt; // R6
        evt[BIT_SCAN_DONE]  = scan_decode_done_evt;   // R6
        evt[BIT_UNDERFLOW]  = buffer_underflow_evt;   // R5
        evt[BIT_SEQ_END_V]  = vtimed[0];              // R7
        evt[BIT_GROUP_SHWN] = vtimed[1];              // R8
        evt[BIT_PIC_SHWN]   = vtimed[2];              // R9
        evt[BIT_SEQ_SHWN]   = vtimed[3];              // R8
        evt[BIT_READY]      = ready_for_data_evt;     // R9
    end

    // ---------------------------------------------------------------
    // wishbone slave: one wait state, ack one cycle
    // ---------------------------------------------------------------
    assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_fire = wb_req & wb_we_i & (&wb_sel_i[1:0]);
    assign clr     = (wr_fire && wb_adr_i == OFS_STATUS) ? wb_dat_i[NUM_SRC-1:0] : '0;

    always_ff @(posedge clock)
    begin
        if (!resetn)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_req;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            wb_dat_o <= 32'h00000000;
        else if (wb_req && !wb_we_i)
            case (wb_adr_i)
                OFS_STATUS:     wb_dat_o <= pad(status);          // R3
                OFS_ENABLE:     wb_dat_o <= pad(enable);
                OFS_PENDING:    wb_dat_o <= pad(status & enable);
                OFS_SET_ENABLE: wb_dat_o <= pad(enable);
                default:        wb_dat_o <= 32'h00000000;
            endcase
    end

    // enables only gate the line; events are always recorded
    always_ff @(posedge clock)
    begin
        if (!resetn)
            enable <= ENABLE_RESET;
        else if (wr_fire && (wb_adr_i == OFS_ENABLE || wb_adr_i == OFS_SET_ENABLE))
            enable <= wb_dat_i[NUM_SRC-1:0]; // R2 R10
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (!resetn)
            status <= STATUS_RESET;
        else
            status <= (status & ~clr) | evt; // R3 R11
    end

    // decoding never waits on the line, it is a pure output
    always_ff @(posedge clock)
    begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |(((status & ~clr) | evt) & enable); // R1 R4 R11
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    // the first cycle out of reset has no meaningful history to compare against
    AST_IRQ_FOLLOWS: assert property (@(posedge clock) disable iff (!resetn) // R11
        $past(resetn) |->
        irq == |((($past(status) & ~$past(clr)) | $past(evt)) & $past(enable)))
        else $error("irq does not follow enabled status");
    AST_UNDERFLOW_SETS: assert property (@(posedge clock) disable iff (!resetn) // R5
        buffer_underflow_evt |=> status[BIT_UNDERFLOW])
        else $error("underflow event lost");
    AST_ERR_SETS: assert property (@(posedge clock) disable iff (!resetn) // R5
        data_error_evt |=> status[BIT_DATA_ERR])
        else $error("data error event lost");
    AST_PICDEC_SETS: assert property (@(posedge clock) disable iff (!resetn) // R6
        picture_decoded_evt |=> status[BIT_PIC_DEC])
        else $error("picture decoded event lost");
    AST_SEQ_END_SETS: assert property (@(posedge clock) disable iff (!resetn) // R6
        seq_end_found_evt |=> status[BIT_SEQ_END_D])
        else $error("sequence end event lost");
    AST_SEQ_HDR_SETS: assert property (@(posedge clock) disable iff (!resetn) // R6
        seq_header_decoded_evt |=> status[BIT_SEQ_HDR])
        else $error("sequence header event lost");
    AST_SCAN_SETS: assert property (@(posedge clock) disable iff (!resetn) // R6
        scan_decode_done_evt |=> status[BIT_SCAN_DONE])
        else $error("scan done event lost");
    AST_READY_SETS: assert property (@(posedge clock) disable iff (!resetn) // R9
        ready_for_data_evt |=> status[BIT_READY])
        else $error("ready for data event lost");
    AST_CLEAR_W1C: assert property (@(posedge clock) disable iff (!resetn) // R11
        (clr[BIT_PIC_DEC] && !evt[BIT_PIC_DEC]) |=> !status[BIT_PIC_DEC])
        else $error("write one did not clear status");
    AST_STATUS_HOLD: assert property (@(posedge clock) disable iff (!resetn) // R3
        (status[BIT_READY] && !clr[BIT_READY]) |=> status[BIT_READY])
        else $error("status bit dropped without clear");
    AST_MASKED_QUIET: assert property (@(posedge clock) disable iff (!resetn) // R2
        (enable == '0) [*2] |-> !irq)
        else $error("irq high with all sources disabled");
    AST_ENABLE_SEL_GUARD: assert property (@(posedge clock) disable iff (!resetn) // R2
        (wb_req && wb_we_i && !(&wb_sel_i[1:0])) |=> $stable(enable))
        else $error("enable changed by a write without low byte lanes");
    AST_PIC_SHOWN_VSYNC: assert property (@(posedge clock) disable iff (!resetn) // R9
        vtimed[2] |-> $past(vsync_s2) && !$past(vsync_s2, 2))
        else $error("picture shown event not at vsync");
    AST_LAST_PIC_VSYNC: assert property (@(posedge clock) disable iff (!resetn) // R7
        vtimed[0] |=> status[BIT_SEQ_END_V])
        else $error("last picture event lost");
    AST_GROUP_VSYNC: assert property (@(posedge clock) disable iff (!resetn) // R8
        vtimed[1] |=> status[BIT_GROUP_SHWN])
        else $error("group start event lost");
    AST_SEQ_SHOWN_VSYNC: assert property (@(posedge clock) disable iff (!resetn) // R8
        vtimed[3] |=> status[BIT_SEQ_SHWN])
        else $error("sequence start shown event lost");
    AST_ACK_ANSWERS: assert property (@(posedge clock) disable iff (!resetn)
        wb_req |=> wb_ack_o)
        else $error("request not acknowledged after one cycle");
    AST_ACK_ONE: assert property (@(posedge clock) disable iff (!resetn)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule

// *** hw/vd_irq_pkg.sv ***
// constants for the video decoder event interrupt block
package vd_irq_pkg;
    localparam int         NUM_SRC        = 11;
    // word byte offsets on the register bus
    localparam logic [7:0] OFS_STATUS     = 8'h00;
    localparam logic [7:0] OFS_ENABLE     = 8'h04;
    localparam logic [7:0] OFS_PENDING    = 8'h08;
    localparam logic [7:0] OFS_SET_ENABLE = 8'h0c;
    // status and enable bit positions
    localparam int         BIT_SEQ_END_D  = 0;
    localparam int         BIT_DATA_ERR   = 1;
    localparam int         BIT_PIC_DEC    = 2;
    localparam int         BIT_SEQ_HDR    = 3;
    localparam int         BIT_SCAN_DONE  = 4;
    localparam int         BIT_UNDERFLOW  = 5;
    localparam int         BIT_SEQ_END_V  = 6;
    localparam int         BIT_GROUP_SHWN = 7;
    localparam int         BIT_PIC_SHWN   = 8;
    localparam int         BIT_SEQ_SHWN   = 9;
    localparam int         BIT_READY      = 10;
    localparam logic [10:0] ENABLE_RESET  = 11'h000;
    localparam logic [10:0] STATUS_RESET  = 11'h000;
endpackage

// *** hw/vsync_event_align.sv ***
// holds display-time events until the next vertical sync edge
`timescale 1ns/1ns
module vsync_event_align
    import vd_irq_pkg::*;
#(
    parameter int WIDTH = 6
)
(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // synchronised vertical sync level
    input  wire logic             vsync,
    // raw display events and events released at vsync
    input  wire logic [WIDTH-1:0] raw_evt,
    output      logic [WIDTH-1:0] timed_evt
);
    logic [WIDTH-1:0] held;
    logic             vsync_d;
    logic             vsync_rise;

    assign vsync_rise = vsync & ~vsync_d;

    always_ff @(posedge clock)
    begin
        if (!resetn)
            vsync_d <= 1'b0;
        else
            vsync_d <= vsync;
    end

    // an event arriving on the release edge is kept for the next frame
    always_ff @(posedge clock)
    begin
        if (!resetn)
            held <= '0;
        else if (vsync_rise)
            held <= raw_evt;
        else
            held <= held | raw_evt;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
            timed_evt <= '0;
        else if (vsync_rise)
            timed_evt <= held;
        else
            timed_evt <= '0;
    end
endmodule

// *** verification/host_bus_model.sv ***
// host processor model: a classic wishbone master that services the interrupt block
`timescale 1ns/1ns
module host_bus_model
(
    // clock
    input  wire logic        clock,
    // wishbone master side
    output      logic        cyc,
    output      logic        stb,
    output      logic        we,
    output      logic [7:0]  adr,
    output      logic [3:0]  sel,
    output      logic [31:0] wdat,
    input  wire logic [31:0] rdat,
    input  wire logic        ack
);
    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'hff;
        sel = 4'h0;
        wdat = 32'hffff_ffff;
    end

    // call right after a rising edge; returns right after an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output bit ok);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        @(posedge clock);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clock);
            n++;
        end
        ok = (ack === 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        // released address and data lines show inverted junk, never the last value; we and sel keep theirs
        adr <= ~a;
        wdat <= ~d;
        @(posedge clock);
    endtask
endmodule

// *** verification/tb_top.sv ***
// self-checking bench of the video decoder event interrupt block
`timescale 1ns/1ns
module tb_top;
    import vd_irq_pkg::*;
    logic        clock, resetn, cyc, stb, we, ack, irq, vsync_pin;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q, seed;
    logic [10:0] evt, mask;
    bit          ok;
    logic [3:0]  bus_sel;
    int          mismatches, checked;

    host_bus_model u_host_bus_model (.clock(clock), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .wdat(wdat), .rdat(rdat), .ack(ack));

    video_decoder_event_interrupts u_video_decoder_event_interrupts (.clock(clock),
        .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .seq_end_found_evt(evt[BIT_SEQ_END_D]), .data_error_evt(evt[BIT_DATA_ERR]),
        .picture_decoded_evt(evt[BIT_PIC_DEC]), .seq_header_decoded_evt(evt[BIT_SEQ_HDR]),
        .scan_decode_done_evt(evt[BIT_SCAN_DONE]), .buffer_underflow_evt(evt[BIT_UNDERFLOW]),
        .last_pic_shown_raw(evt[BIT_SEQ_END_V]), .group_start_shown_raw(evt[BIT_GROUP_SHWN]),
        .picture_shown_raw(evt[BIT_PIC_SHWN]), .seq_start_shown_raw(evt[BIT_SEQ_SHWN]),
        .ready_for_data_evt(evt[BIT_READY]), .vsync_pin(vsync_pin), .irq(irq));

    always #2 clock = ~clock;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [31:0] exp_pending(input logic [10:0] st, input logic [10:0] en);
        return {21'h0, st & en};
    endfunction

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic check_flag(input string name, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", name, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        u_host_bus_model.xfer(w, a, d, bus_sel, q, ok);
        if (!ok)
        begin
            mismatches++;
            $display("[ERR] bus ack expected 1 seen 0");
            give_verdict();
        end
    endtask

    initial
    begin
        clock = 1'b0;
        resetn = 1'b0;
        evt = '0;
        vsync_pin = 1'b0;
        seed = 32'h3e1c;
        bus_sel = 4'hf;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        bus(1'b0, OFS_STATUS, 32'h0);
        check_word("status reset", {21'h0, STATUS_RESET}, q);
        bus(1'b0, OFS_ENABLE, 32'h0);
        check_word("enable reset", {21'h0, ENABLE_RESET}, q);
        check_flag("irq reset", 1'b0, irq);
        bus(1'b0, 8'h10, 32'h0);
        check_word("unmapped read", 32'h0, q);
        // a write without the low byte lanes must leave the enables alone
        bus_sel = 4'hc;
        bus(1'b1, OFS_ENABLE, 32'h0000_07ff);
        bus_sel = 4'hf;
        bus(1'b0, OFS_ENABLE, 32'h0);
        check_word("enable partial sel", 32'h0, q);
        $display("test reset done");
        // first pass all enabled, second none, then random masks
        for (int r = 0; r < 4; r++)
        begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
                seed = xorshift(seed);
                mask = (r == 0) ? 11'h7ff : (r == 1) ? 11'h000 : seed[10:0];
                bus(1'b1, i[0] ? OFS_SET_ENABLE : OFS_ENABLE, {21'h0, mask});
                bus(1'b0, OFS_ENABLE, 32'h0);
                check_word("enable", {21'h0, mask}, q);
                evt[i] <= 1'b1;
                @(posedge clock);
                evt[i] <= 1'b0;
                if (i >= BIT_SEQ_END_V && i <= BIT_SEQ_SHWN)
                begin
                    bus(1'b0, OFS_STATUS, 32'h0);
                    check_word("status before vsync", 32'h0, q);
                    vsync_pin <= 1'b1;
                    repeat (8) @(posedge clock);
                    vsync_pin <= 1'b0;
                end
                repeat (2) @(posedge clock);
                check_flag("irq set", mask[i], irq);
                bus(1'b0, OFS_STATUS, 32'h0);
                check_word("status", 32'h1 << i, q);
                bus(1'b0, OFS_PENDING, 32'h0);
                check_word("pending", exp_pending(11'h1 << i, mask), q);
                bus(1'b1, OFS_STATUS, 32'h1 << i);
                bus(1'b0, OFS_STATUS, 32'h0);
                check_word("status cleared", 32'h0, q);
                check_flag("irq cleared", 1'b0, irq);
            end
            $display("test pass %0d done", r);
        end
        // several sources at once, partial clear leaves the rest
        evt <= 11'h43f;
        @(posedge clock);
        evt <= '0;
        repeat (2) @(posedge clock);
        bus(1'b1, OFS_STATUS, 32'h03f);
        bus(1'b0, OFS_STATUS, 32'h0);
        check_word("status partial", 32'h400, q);
        check_flag("irq partial", mask[BIT_READY], irq);
        $display("test multi done");
        give_verdict();
    end
endmodule
